//--- src/hhs_regs.svh
/*
 Constants of the host hardware setup register: command codes, reset
 value, writable mask and input pin indices.
 Assumes inclusion by bare name from the package and the top module.
*/
`ifndef HHS_REGS_SVH
`define HHS_REGS_SVH

`define HHS_CMD_RD 8'h20
`define HHS_CMD_WR 8'ha0
`define HHS_RESET 16'h0028
`define HHS_WMASK 16'h1ca7
`define HHS_FIXED 16'h0008
`define HHS_RSVD 16'he340
`define HHS_BUS16 2'h1
`define HHS_NPINS 6
`define HHS_PIN_EOT 0
`define HHS_PIN_ACK 1
`define HHS_PIN_RD_N 2
`define HHS_PIN_WR_N 3
`define HHS_PIN_OVC_N 4
`define HHS_PIN_OVC_AN 5
`define HHS_SYNC_RESET 6'h1f

`endif

//--- src/hhs_pkg.sv
/*
 Types of the host hardware setup block.
 Assumes the constants header is on the include path.
*/
`include "hhs_regs.svh"

package hhs_pkg;

    typedef struct packed {
        logic [2:0] rsvd_hi;
        logic pulldown_source_sel;
        logic keep_clock_in_suspend;
        logic onchip_overcurrent_sel;
        logic rsvd_9;
        logic ack_strobe_mode;
        logic end_of_transfer_in_pol;
        logic ack_in_pol;
        logic dma_req_out_pol;
        logic [1:0] bus_width_field;
        logic irq_out_pol;
        logic irq_trigger_sel;
        logic master_irq_gate;
    } hhs_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } hhs_cmd_t;

endpackage : hhs_pkg

//--- src/hhs_top.sv
/*
 Host hardware setup register with the pin logic it steers: interrupt
 gating, trigger and polarity, DMA request polarity, acknowledge
 qualification, end-of-transfer polarity, overcurrent source and port options.
 Assumes the command and data strobes, pending sources and mask come
 from logic on i_clk; the device pins arrive asynchronously.
*/
`include "hhs_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module hhs_top (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire hhs_pkg::hhs_cmd_t i_cmd,
    input wire logic i_wr_valid,
    input wire logic [15:0] i_wr_data,
    input wire logic [15:0] i_src_pending,
    input wire logic [15:0] i_cpu_irq_mask,
    input wire logic i_dma_req,
    input wire logic i_eot_pin,
    input wire logic i_dma_ack_pin,
    input wire logic i_rd_strobe_n,
    input wire logic i_wr_strobe_n,
    input wire logic i_ovc_digital_n,
    input wire logic i_ovc_analog,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_host_irq_pin,
    output logic o_dma_req_pin,
    output logic o_eot_active,
    output logic o_dma_ack_active,
    output logic o_pulldown_internal,
    output logic o_keep_clock,
    output logic o_onchip_oc_sel,
    output logic o_overcurrent
);
    import hhs_pkg::*;

    hhs_cfg_t cfg_q;
    hhs_cfg_t cfg_d;
    logic wr_armed_q;
    logic wr_armed_d;
    logic irq_req_q;
    logic [`HHS_NPINS-1:0] sync1_q;
    logic [`HHS_NPINS-1:0] sync2_q;

    // Command decode
    wire sel_rd = i_cmd.valid && (i_cmd.code == `HHS_CMD_RD);
    wire sel_wr = i_cmd.valid && (i_cmd.code == `HHS_CMD_WR);
    wire do_write = wr_armed_q && i_wr_valid;

    // Any other command deselects the register, so stray data is ignored
    assign wr_armed_d = sel_wr ? 1'b1 :
                        (i_cmd.valid || do_write) ? 1'b0 : wr_armed_q;

    // Reserved and fixed bits never take written values
    wire [15:0] wr_value = (i_wr_data & `HHS_WMASK) | `HHS_FIXED;
    assign cfg_d = do_write ? hhs_cfg_t'(wr_value) : cfg_q;

    // Interrupt request
    wire src_hit = |(i_src_pending & i_cpu_irq_mask);
    wire irq_req = cfg_q.master_irq_gate && src_hit;
    // Edge mode gives one pulse per rising request
    wire irq_act = cfg_q.irq_trigger_sel ? (irq_req && !irq_req_q) : irq_req;
    wire irq_pin_d = cfg_q.irq_out_pol ? irq_act : !irq_act;

    wire req_pin_d = cfg_q.dma_req_out_pol ? i_dma_req : !i_dma_req;

    // Synchronised pins, converted to active high
    wire eot_s = sync2_q[`HHS_PIN_EOT];
    wire ack_s = sync2_q[`HHS_PIN_ACK];
    wire eot_act = cfg_q.end_of_transfer_in_pol ? eot_s : !eot_s;
    wire ack_act = cfg_q.ack_in_pol ? ack_s : !ack_s;
    wire strobe_act = !sync2_q[`HHS_PIN_RD_N] || !sync2_q[`HHS_PIN_WR_N];
    // Only strobe-qualified mode exists; the reserved mode cannot be set
    wire ack_q_d = ack_act && strobe_act;
    wire ovc_d = cfg_q.onchip_overcurrent_sel ? sync2_q[`HHS_PIN_OVC_AN] :
                 !sync2_q[`HHS_PIN_OVC_N];

    wire [`HHS_NPINS-1:0] pins_raw = {i_ovc_analog, i_ovc_digital_n, i_wr_strobe_n,
                                     i_rd_strobe_n, i_dma_ack_pin, i_eot_pin};

    // Synchronisers leave reset at the pins' idle levels, so no false event follows
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_q <= `HHS_SYNC_RESET;
            sync2_q <= `HHS_SYNC_RESET;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_q <= hhs_cfg_t'(`HHS_RESET);
            wr_armed_q <= 1'b0;
            irq_req_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            wr_armed_q <= wr_armed_d;
            irq_req_q <= irq_req;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= 16'h0000;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= sel_rd;
            if (sel_rd) begin
                o_rd_data <= cfg_q;
            end
        end
    end

    // Pin drivers; reset levels match the power-up polarities
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_host_irq_pin <= 1'b1;
            o_dma_req_pin <= 1'b0;
            o_eot_active <= 1'b0;
            o_dma_ack_active <= 1'b0;
            o_overcurrent <= 1'b0;
        end else begin
            o_host_irq_pin <= irq_pin_d;
            o_dma_req_pin <= req_pin_d;
            o_eot_active <= eot_act;
            o_dma_ack_active <= ack_q_d;
            o_overcurrent <= ovc_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pulldown_internal <= 1'b0;
            o_keep_clock <= 1'b0;
            o_onchip_oc_sel <= 1'b0;
        end else begin
            o_pulldown_internal <= cfg_q.pulldown_source_sel;
            o_keep_clock <= cfg_q.keep_clock_in_suspend;
            o_onchip_oc_sel <= cfg_q.onchip_overcurrent_sel;
        end
    end

    default clocking dflt_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    gate_closed_a: assert property (
        !cfg_q.master_irq_gate |=> o_host_irq_pin == !$past(cfg_q.irq_out_pol)
    ) else $error("interrupt pin active with gate closed");

    mask_block_a: assert property (
        !src_hit |=> o_host_irq_pin == !$past(cfg_q.irq_out_pol)
    ) else $error("interrupt pin active with no unmasked source");

    level_irq_a: assert property (
        (irq_req && !cfg_q.irq_trigger_sel)
        |=> o_host_irq_pin == $past(cfg_q.irq_out_pol)
    ) else $error("level interrupt not driven");

    bus_width_a: assert property (
        cfg_q.bus_width_field == `HHS_BUS16
    ) else $error("bus width field left 16-bit code");

    read_cmd_a: assert property (
        sel_rd |=> o_rd_valid && (o_rd_data == $past(cfg_q))
    ) else $error("read command did not return register");

    write_cmd_a: assert property (
        sel_wr ##1 (i_wr_valid && !i_cmd.valid)
        |=> cfg_q == hhs_cfg_t'(($past(i_wr_data) & `HHS_WMASK) | `HHS_FIXED)
    ) else $error("write command did not update register");

    no_arm_a: assert property (
        (!wr_armed_q && !sel_wr) ##1 (i_wr_valid && !wr_armed_q) |=> $stable(cfg_q)
    ) else $error("unselected data write changed register");

    // Pipeline checks skip the first edge after reset, where outputs hold reset values
    pulldown_a: assert property (
        $past(i_reset_n) |-> o_pulldown_internal == $past(cfg_q.pulldown_source_sel)
    ) else $error("pull-down select not following register");

    keep_clock_a: assert property (
        $past(i_reset_n) |-> o_keep_clock == $past(cfg_q.keep_clock_in_suspend)
    ) else $error("suspend clock select not following register");

    ovc_source_a: assert property (
        cfg_q.onchip_overcurrent_sel |=> o_overcurrent == $past(sync2_q[`HHS_PIN_OVC_AN])
    ) else $error("analog overcurrent source not used");

    ack_mode_a: assert property (
        !cfg_q.ack_strobe_mode && !cfg_q.ack_in_pol
    ) else $error("reserved acknowledge setting stored");

    eot_pol_a: assert property (
        $past(i_reset_n)
        |-> o_eot_active == ($past(eot_s) == $past(cfg_q.end_of_transfer_in_pol))
    ) else $error("end-of-transfer polarity wrong");

    dreq_pol_a: assert property (
        $past(i_reset_n)
        |-> o_dma_req_pin == ($past(i_dma_req) == $past(cfg_q.dma_req_out_pol))
    ) else $error("DMA request polarity wrong");

    edge_pulse_a: assert property (
        (cfg_q.irq_trigger_sel && irq_req && irq_req_q)
        |=> o_host_irq_pin == !$past(cfg_q.irq_out_pol)
    ) else $error("edge interrupt held longer than one cycle");

    reserved_zero_a: assert property (
        (cfg_q & `HHS_RSVD) == 16'h0000
    ) else $error("reserved bit set in register");

    rd_pulse_a: assert property (
        !sel_rd |=> !o_rd_valid
    ) else $error("read valid without read command");

    rd_hold_a: assert property (
        !sel_rd |=> $stable(o_rd_data)
    ) else $error("read data changed without read command");

    arm_set_a: assert property (
        sel_wr |=> wr_armed_q
    ) else $error("write command did not arm the register");

    arm_clear_a: assert property (
        (i_cmd.valid && !sel_wr) |=> !wr_armed_q
    ) else $error("other command left the write armed");

    arm_used_a: assert property (
        (do_write && !i_cmd.valid) |=> !wr_armed_q
    ) else $error("write stayed armed after its data word");

    data_take_a: assert property (
        (wr_armed_q && i_wr_valid && !i_cmd.valid)
        |=> cfg_q == hhs_cfg_t'(($past(i_wr_data) & `HHS_WMASK) | `HHS_FIXED)
    ) else $error("armed data word not stored");

    cfg_hold_a: assert property (
        !do_write |=> $stable(cfg_q)
    ) else $error("register changed without a data write");

    fixed_write_a: assert property (
        do_write |=> cfg_q.bus_width_field == `HHS_BUS16 && !cfg_q.rsvd_9 && cfg_q.rsvd_hi == '0
    ) else $error("write reached fixed or reserved bits");

    gate_pass_a: assert property (
        (cfg_q.master_irq_gate && src_hit && !cfg_q.irq_trigger_sel)
        |=> o_host_irq_pin == $past(cfg_q.irq_out_pol)
    ) else $error("enabled level interrupt not driven");

    edge_first_a: assert property (
        (cfg_q.irq_trigger_sel && irq_req && !irq_req_q)
        |=> o_host_irq_pin == $past(cfg_q.irq_out_pol)
    ) else $error("edge interrupt pulse missing");

    edge_idle_a: assert property (
        (cfg_q.irq_trigger_sel && !irq_req)
        |=> o_host_irq_pin == !$past(cfg_q.irq_out_pol)
    ) else $error("edge interrupt active with no request");

    req_track_a: assert property (
        $past(i_reset_n) |-> irq_req_q == $past(irq_req)
    ) else $error("request history out of step");

    ack_qual_a: assert property (
        $past(i_reset_n) |-> o_dma_ack_active == ($past(ack_s == cfg_q.ack_in_pol)
            && !$past(sync2_q[`HHS_PIN_RD_N] && sync2_q[`HHS_PIN_WR_N]))
    ) else $error("acknowledge not qualified by strobes");

    ack_idle_a: assert property (
        (sync2_q[`HHS_PIN_RD_N] && sync2_q[`HHS_PIN_WR_N]) |=> !o_dma_ack_active
    ) else $error("acknowledge active with no strobe");

    ovc_digital_a: assert property (
        !cfg_q.onchip_overcurrent_sel |=> o_overcurrent == !$past(sync2_q[`HHS_PIN_OVC_N])
    ) else $error("digital overcurrent source not used");

    oc_select_a: assert property (
        $past(i_reset_n) |-> o_onchip_oc_sel == $past(cfg_q.onchip_overcurrent_sel)
    ) else $error("overcurrent select not following register");

    eot_low_a: assert property (
        (!cfg_q.end_of_transfer_in_pol && eot_s) |=> !o_eot_active
    ) else $error("idle high end-of-transfer seen as active");

    dreq_low_a: assert property (
        (!cfg_q.dma_req_out_pol && i_dma_req) |=> !o_dma_req_pin
    ) else $error("low DMA request pin driven high");

    dreq_high_a: assert property (
        (cfg_q.dma_req_out_pol && i_dma_req) |=> o_dma_req_pin
    ) else $error("high DMA request pin not driven");

    read_cov_c: cover property (sel_rd ##1 o_rd_valid);
    write_cov_c: cover property (sel_wr ##1 do_write);
    edge_cov_c: cover property (cfg_q.irq_trigger_sel && irq_req ##1 irq_req);
    level_cov_c: cover property (!cfg_q.irq_trigger_sel && irq_req [*3]);
    stray_cov_c: cover property (!wr_armed_q && i_wr_valid);

endmodule : hhs_top

`default_nettype wire

//--- sim/hhs_cpu_model.sv
/*
 Processor bus model: issues read and write command codes and data words.
 Assumes the register block samples everything on the rising edge of i_clk.
*/
`include "hhs_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module hhs_cpu_model (
    input wire logic i_clk,
    output var hhs_pkg::hhs_cmd_t o_cmd,
    output logic o_wr_valid,
    output logic [15:0] o_wr_data
);
    import hhs_pkg::*;

    initial begin
        o_cmd = '0;
        o_wr_valid = 1'b0;
        o_wr_data = 16'h0000;
    end

    task automatic write_reg(input logic [15:0] d);
        @(posedge i_clk);
        o_cmd <= '{valid: 1'b1, code: `HHS_CMD_WR};
        @(posedge i_clk);
        o_cmd <= '0;
        o_wr_valid <= 1'b1;
        o_wr_data <= d;
        @(posedge i_clk);
        o_wr_valid <= 1'b0;
        // Released data lines must not look like a valid word
        o_wr_data <= ~d;
    endtask : write_reg

    // Data strobe with no write command before it; the block must drop it
    task automatic data_only(input logic [15:0] d);
        @(posedge i_clk);
        o_wr_valid <= 1'b1;
        o_wr_data <= d;
        @(posedge i_clk);
        o_wr_valid <= 1'b0;
        o_wr_data <= ~d;
    endtask : data_only

    // Write command cancelled by another command before its data word
    task automatic arm_then(input logic [7:0] c, input logic [15:0] d);
        @(posedge i_clk);
        o_cmd <= '{valid: 1'b1, code: `HHS_CMD_WR};
        @(posedge i_clk);
        o_cmd <= '{valid: 1'b1, code: c};
        @(posedge i_clk);
        o_cmd <= '0;
        o_wr_valid <= 1'b1;
        o_wr_data <= d;
        @(posedge i_clk);
        o_wr_valid <= 1'b0;
        o_wr_data <= ~d;
    endtask : arm_then

    task automatic read_cmd();
        @(posedge i_clk);
        o_cmd <= '{valid: 1'b1, code: `HHS_CMD_RD};
        @(posedge i_clk);
        o_cmd <= '0;
    endtask : read_cmd
endmodule : hhs_cpu_model

`default_nettype wire

//--- sim/host_hw_config_register_tb.sv
/*
 Self-checking bench of the host hardware setup register.
 Assumes hhs_top and the processor bus model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module host_hw_config_register_tb;
    import hhs_pkg::*;
    logic i_clk, i_reset_n, i_wr_valid, i_dma_req;
    hhs_cmd_t i_cmd;
    logic [15:0] i_wr_data, i_src_pending, i_cpu_irq_mask, o_rd_data;
    logic i_eot_pin, i_dma_ack_pin, i_rd_strobe_n, i_wr_strobe_n, i_ovc_digital_n, i_ovc_analog;
    logic o_rd_valid, o_host_irq_pin, o_dma_req_pin, o_eot_active, o_dma_ack_active;
    logic o_pulldown_internal, o_keep_clock, o_onchip_oc_sel, o_overcurrent;
    logic [5:0] pv;
    int fail_count = 0;
    int checks_done = 0;
    assign {i_eot_pin, i_dma_ack_pin, i_rd_strobe_n, i_wr_strobe_n, i_ovc_digital_n,
            i_ovc_analog} = pv;

    hhs_top uut (.i_clk, .i_reset_n, .i_cmd, .i_wr_valid, .i_wr_data, .i_src_pending,
        .i_cpu_irq_mask, .i_dma_req, .i_eot_pin, .i_dma_ack_pin, .i_rd_strobe_n,
        .i_wr_strobe_n, .i_ovc_digital_n, .i_ovc_analog, .o_rd_data, .o_rd_valid,
        .o_host_irq_pin, .o_dma_req_pin, .o_eot_active, .o_dma_ack_active,
        .o_pulldown_internal, .o_keep_clock, .o_onchip_oc_sel, .o_overcurrent);
    hhs_cpu_model cpu (.i_clk(i_clk), .o_cmd(i_cmd), .o_wr_valid(i_wr_valid),
        .o_wr_data(i_wr_data));

    task automatic chkw(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chkw

    task automatic chk(input string n, input logic e, input logic g);
        chkw(n, {15'h0000, e}, {15'h0000, g});
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : wt

    task automatic rd(input logic [15:0] e);
        cpu.read_cmd();
        #1;
        chk("rd_valid", 1'b1, o_rd_valid);
        chkw("readback", e, o_rd_data);
        wt(1);
        chk("rd_valid end", 1'b0, o_rd_valid);
    endtask : rd

    // Pins go through two synchroniser stages, so four edges settle everything
    task automatic pins(input logic [5:0] v);
        @(posedge i_clk);
        pv <= v;
        wt(4);
    endtask : pins

    task automatic pm(input logic [15:0] p, input logic [15:0] m);
        @(posedge i_clk);
        i_src_pending <= p;
        i_cpu_irq_mask <= m;
        wt(4);
    endtask : pm

    task automatic wr(input logic [15:0] d);
        cpu.write_reg(d);
        wt(4);
    endtask : wr

    task automatic t_reset();
        rd(16'h0028);
        chk("irq gated", 1'b1, o_host_irq_pin);
        chk("dreq high", 1'b1, o_dma_req_pin);
        chk("pulldown", 1'b0, o_pulldown_internal);
        chk("keep clk", 1'b0, o_keep_clock);
        chk("oc sel", 1'b0, o_onchip_oc_sel);
        chk("eot idle", 1'b0, o_eot_active);
        chk("oc idle", 1'b0, o_overcurrent);
        $display("test reset done");
    endtask : t_reset

    task automatic t_write();
        pm(16'h0000, 16'h0000);
        wr(16'hffff);
        rd(16'h1caf);
        chk("pulldown", 1'b1, o_pulldown_internal);
        chk("keep clk", 1'b1, o_keep_clock);
        chk("oc sel", 1'b1, o_onchip_oc_sel);
        wr(16'h0000);
        rd(16'h0008);
        cpu.data_only(16'hffff);
        wt(4);
        rd(16'h0008);
        cpu.arm_then(8'h21, 16'hffff);
        wt(4);
        rd(16'h0008);
        $display("test write done");
    endtask : t_write

    task automatic t_irq();
        int n;
        n = 0;
        wr(16'h0001);
        pm(16'h0004, 16'h0004);
        chk("irq low", 1'b0, o_host_irq_pin);
        pm(16'h0004, 16'h0000);
        chk("irq masked", 1'b1, o_host_irq_pin);
        pm(16'h0004, 16'h0004);
        wr(16'h0000);
        chk("irq gate off", 1'b1, o_host_irq_pin);
        wr(16'h0005);
        chk("irq high", 1'b1, o_host_irq_pin);
        pm(16'h0000, 16'hffff);
        wr(16'h0007);
        @(posedge i_clk);
        i_src_pending <= 16'h0001;
        for (int k = 0; k < 8; k++) begin
            @(posedge i_clk);
            #1;
            if (o_host_irq_pin === 1'b1) n++;
        end
        chkw("edge pulses", 16'h0001, n[15:0]);
        $display("test irq done");
    endtask : t_irq

    task automatic t_pins();
        wr(16'h0000);
        chk("dreq low pol", 1'b0, o_dma_req_pin);
        pins(6'b111101);
        chk("eot low act", 1'b0, o_eot_active);
        pins(6'b000101);
        chk("eot low act", 1'b1, o_eot_active);
        chk("ack qual", 1'b1, o_dma_ack_active);
        pins(6'b101100);
        chk("ack no strobe", 1'b0, o_dma_ack_active);
        chk("oc digital", 1'b1, o_overcurrent);
        pins(6'b101000);
        chk("ack wr strobe", 1'b1, o_dma_ack_active);
        wr(16'h04a0);
        chk("dreq high pol", 1'b1, o_dma_req_pin);
        chk("eot high act", 1'b1, o_eot_active);
        chk("oc analog off", 1'b0, o_overcurrent);
        pins(6'b100101);
        chk("oc analog on", 1'b1, o_overcurrent);
        $display("test pins done");
    endtask : t_pins

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    initial begin
        i_reset_n = 1'b0;
        i_src_pending = 16'hffff;
        i_cpu_irq_mask = 16'hffff;
        i_dma_req = 1'b1;
        pv = 6'b111110;
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        wt(4);
        t_reset();
        t_write();
        t_irq();
        t_pins();
        end_of_test();
    end
endmodule : host_hw_config_register_tb

`default_nettype wire
